// *** counter_channel_pwm_output.sv ***
/*
  pwm output of one high-speed counter channel with its register port,
  setting checks, error reporting and a level interrupt.
  assumes a synchronous master that never waits and strobes for one cycle.
  a request held high out of reset must drop once before any output starts.
*/
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "pwm_chan_defines.svh"
module counter_channel_pwm_output
  import pwm_chan_pkg::*;
#(
  parameter int TICK_DIV = `TICK_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [31:0] rd_data_out,
  output logic             pwm_out,
  output logic             irq_out
);

  logic [5:0]   ctrl;
  pwm_setting_t setting;
  pwm_setting_t active;
  logic         operation_error_flag;
  logic [15:0]  operation_error_code;
  logic [2:0]   int_stat;
  logic [2:0]   int_mask;
  logic         armed;
  logic         running;
  logic [31:0]  unit_cnt;
  logic [15:0]  tick_cnt;
  logic         tick;
  logic         pwm_request_ch1;
  pwm_check_t   chk;
  logic         err_any;
  logic [15:0]  err_code;
  logic         start;
  logic         wrap;
  logic         next_level;
  logic [2:0]   int_evt;
  logic [2:0]   w1c;
  logic [31:0]  high_run;

  // the request is a plain control bit that software toggles every scan
  assign pwm_request_ch1 = ctrl[`CTRL_REQ];

  // checks run every cycle regardless of the request level
  // a setting written mid-run is judged at once, and its fault stops the waveform
  always_comb begin
    chk.loc_bad   = ctrl[`CTRL_ON_BAD] | ctrl[`CTRL_CYC_BAD];
    chk.mode_bad  = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] != `MODE_PWM
                    || !ctrl[`CTRL_HSC_EN];
    chk.range_bad = (setting.on_width != 32'h0 && setting.on_width < `ON_MIN)
                    || setting.on_width > `SET_MAX
                    || setting.cycle < `CYC_MIN || setting.cycle > `SET_MAX
                    || setting.on_width > setting.cycle;
  end

  // location faults outrank mode faults, which outrank value faults
  // the code register shows the highest-ranked fault present and keeps the last code after all faults go, until cleared
  always_comb begin
    err_any  = chk.loc_bad | chk.mode_bad | chk.range_bad;
    err_code = `CODE_RANGE;
    if (chk.loc_bad) begin
      err_code = `CODE_LOC;
    end else if (chk.mode_bad) begin
      err_code = `CODE_MODE;
    end
  end

  // start needs a seen-low request; the pin level follows the period position
  assign start = armed && pwm_request_ch1 && !err_any && !running;
  assign wrap  = running && tick && unit_cnt == active.cycle - 32'h1;
  assign next_level = running && unit_cnt < active.on_width;
  assign int_evt = {wrap, start, err_any};
  assign w1c = (wr_en_in && addr_in == `ADDR_INT_STAT) ? wr_data_in[2:0] : 3'h0;

  // control and setting registers written by software
  // settings are stored as written; the range checks above judge them
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl    <= 6'h00;
      setting <= '0;
      int_mask <= 3'h0;
    end else if (wr_en_in) begin
      unique case (addr_in)
        `ADDR_CTRL:     ctrl <= wr_data_in[5:0];
        `ADDR_ON_WIDTH: setting.on_width <= wr_data_in;
        `ADDR_CYCLE:    setting.cycle <= wr_data_in;
        `ADDR_INT_MASK: int_mask <= wr_data_in[2:0];
        default: ;
      endcase
    end
  end

  // error flag and code; a new error wins over a clear in the same cycle
  // clearing while the cause remains is useless: the checks set it again
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      operation_error_flag <= 1'b0;
      operation_error_code <= 16'h0000;
    end else if (err_any) begin
      operation_error_flag <= 1'b1;
      operation_error_code <= err_code;
    end else if (wr_en_in && addr_in == `ADDR_STATUS && wr_data_in[0]) begin
      operation_error_flag <= 1'b0;
      operation_error_code <= 16'h0000;
    end
  end

  // sticky interrupt status, set beats write-one-to-clear
  // irq lags the status by one cycle so that it comes straight from a flop
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_stat <= 3'h0;
      irq_out  <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~w1c) | int_evt;
      irq_out  <= |(int_stat & int_mask);
    end
  end

  // arming needs the request seen low; a one-shot routine never arms
  // an error stops the waveform too, so a restart needs a fresh low request
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      armed   <= 1'b0;
      running <= 1'b0;
      active  <= '0;
    end else begin
      if (!pwm_request_ch1) begin
        armed <= 1'b1;
      end else if (start) begin
        armed <= 1'b0;
      end
      if (start) begin
        running <= 1'b1;
        active  <= setting;             // settings latched at the edge
      end else if (!pwm_request_ch1 || err_any) begin
        running <= 1'b0;
      end
    end
  end

  // 0.1 us time base; restarts with each waveform so the first period is whole
  // trade-off: a free-running base would save the clear but cut the first unit
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt <= 16'h0;
      tick     <= 1'b0;
    end else if (!running) begin
      tick_cnt <= 16'h0;
      tick     <= 1'b0;
    end else begin
      tick     <= tick_cnt == 16'(TICK_DIV - 2);
      tick_cnt <= (tick_cnt == 16'(TICK_DIV - 1)) ? 16'h0 : tick_cnt + 16'h1;
    end
  end

  // position within the period in 0.1 us units
  // wraps on the last tick of the period, so n units last exactly n ticks
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unit_cnt <= 32'h0;
    end else if (!running) begin
      unit_cnt <= 32'h0;
    end else if (tick) begin
      unit_cnt <= wrap ? 32'h0 : unit_cnt + 32'h1;
    end
  end

  // registered pin so the output never glitches on counter decode
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= next_level;
    end
  end

  // read port; unmapped addresses answer zero
  // data stand for one cycle only; the master must take them then
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out <= 32'h0;
    end else if (rd_en_in) begin
      unique case (addr_in)
        `ADDR_CTRL:     rd_data_out <= {26'h0, ctrl};
        `ADDR_ON_WIDTH: rd_data_out <= setting.on_width;
        `ADDR_CYCLE:    rd_data_out <= setting.cycle;
        `ADDR_STATUS:   rd_data_out <= {29'h0, pwm_out, running, operation_error_flag};
        `ADDR_ERR_CODE: rd_data_out <= {16'h0, operation_error_code};
        `ADDR_INT_STAT: rd_data_out <= {29'h0, int_stat};
        `ADDR_INT_MASK: rd_data_out <= {29'h0, int_mask};
        default:        rd_data_out <= 32'h0;
      endcase
    end else begin
      rd_data_out <= 32'h0;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  // error codes and the error flag
  AST_RANGE_CODE: assert property (
    chk.range_bad && !chk.loc_bad && !chk.mode_bad |=> operation_error_code == `CODE_RANGE)
    else $error("value fault did not give code 4100");
  AST_ORDER_CODE: assert property (
    setting.on_width > setting.cycle && !chk.loc_bad && !chk.mode_bad
    |=> operation_error_code == `CODE_RANGE && operation_error_flag)
    else $error("high time above period not flagged");
  AST_LOC_CODE: assert property (
    chk.loc_bad |=> operation_error_code == `CODE_LOC)
    else $error("location fault did not give code 4101");
  AST_MODE_CODE: assert property (
    ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] != `MODE_PWM && !chk.loc_bad
    |=> operation_error_code == `CODE_MODE)
    else $error("wrong mode did not give code 4116");
  AST_ENABLE_CODE: assert property (
    !ctrl[`CTRL_HSC_EN] && !chk.loc_bad |=> operation_error_code == `CODE_MODE)
    else $error("disabled counter did not give code 4116");
  AST_FLAG_SET: assert property (
    err_any |=> operation_error_flag && int_stat[`INT_ERR])
    else $error("error did not set flag");
  AST_IDLE_CHECK: assert property (
    !pwm_request_ch1 && chk.range_bad |=> operation_error_flag)
    else $error("check skipped while request low");
  // start, stop and the shape of the waveform
  AST_EDGE_START: assert property (
    $rose(running) |-> $past(armed) && $past(pwm_request_ch1))
    else $error("waveform started without a seen low request");
  AST_STOP: assert property (
    !pwm_request_ch1 |=> !running ##1 !pwm_out)
    else $error("output kept running after request dropped");
  AST_ZERO_LOW: assert property (
    running && active.on_width == 32'h0 |=> !pwm_out)
    else $error("zero high time drove output high");
  AST_FIRST_HIGH: assert property (
    $rose(running) && active.on_width != 32'h0 |=> pwm_out [*8])
    else $error("first high phase too short");

  // run length of the high phase, judged at each fall inside one waveform;
  // a stop or an error also drops the pin, but running is low by then
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      high_run <= 32'h0;
    end else if (pwm_out) begin
      high_run <= high_run + 32'h1;
    end else begin
      high_run <= 32'h0;
    end
  end

  AST_HIGH_LEN: assert property (
    $fell(pwm_out) && running && $past(running) |-> high_run == active.on_width * 32'(TICK_DIV))
    else $error("high phase length differs from setting");
  AST_ERR_STOPS: assert property (
    running && err_any |=> !running)
    else $error("waveform kept running through an error");
  AST_NO_REARM: assert property (
    running && pwm_request_ch1 |-> !armed)
    else $error("channel armed while a waveform runs");
  AST_PWM_IDLE: assert property (
    !running |=> !pwm_out)
    else $error("output high without a running waveform");
  AST_LATCH_HOLD: assert property (
    running |=> !running || $stable(active))
    else $error("settings changed under a running waveform");
  AST_UNIT_BOUND: assert property (
    running |-> unit_cnt < active.cycle)
    else $error("period position passed the period");
  AST_WRAP_ZERO: assert property (
    wrap |=> unit_cnt == 32'h0)
    else $error("period did not restart at wrap");
  AST_TICK_GAP: assert property (
    tick |=> !tick)
    else $error("time base ticked twice in a row");

  // error code contents and the interrupt line
  AST_CODE_HOLD: assert property (
    operation_error_flag |-> operation_error_code != 16'h0000)
    else $error("error flag set with an empty code");
  AST_IRQ_RAISE: assert property (
    int_stat[`INT_ERR] && int_mask[`INT_ERR] |=> irq_out)
    else $error("unmasked error did not raise the interrupt");
  AST_IRQ_MASKED: assert property (
    int_mask == 3'h0 |=> !irq_out)
    else $error("masked status raised the interrupt");

  // main scenarios
  COV_START: cover property ($rose(running));
  COV_WRAP:  cover property (wrap ##[1:300] pwm_out);
  COV_ERR:   cover property (err_any && !pwm_request_ch1);
  COV_IRQ:   cover property ($rose(irq_out));
  COV_ZERO:  cover property (running && active.on_width == 32'h0);

endmodule // counter_channel_pwm_output

// *** pwm_chan_defines.svh ***
/*
  register offsets, field positions, codes and timing counts of the pwm channel.
  assumes a 100 MHz system clock and a word-wide register port.
*/
`ifndef PWM_CHAN_DEFINES_SVH
`define PWM_CHAN_DEFINES_SVH
`define ADDR_CTRL      8'h00
`define ADDR_ON_WIDTH  8'h04
`define ADDR_CYCLE     8'h08
`define ADDR_STATUS    8'h10
`define ADDR_ERR_CODE  8'h14
`define ADDR_INT_STAT  8'h18
`define ADDR_INT_MASK  8'h1c
`define CTRL_REQ       0
`define CTRL_HSC_EN    1
`define CTRL_MODE_LO   2
`define CTRL_MODE_HI   3
`define CTRL_ON_BAD    4
`define CTRL_CYC_BAD   5
`define MODE_PWM       2'h3
`define ON_MIN         32'h0000_000a
`define CYC_MIN        32'h0000_0032
`define SET_MAX        32'h0098_9680
`define CODE_RANGE     16'h1004
`define CODE_LOC       16'h1005
`define CODE_MODE      16'h1014
`define UNIT_NS        100
`define CLK_PERIOD_NS  10
`define TICK_CYCLES    (`UNIT_NS / `CLK_PERIOD_NS)
`define INT_ERR        0
`define INT_START      1
`define INT_WRAP       2
`endif

// *** pwm_chan_pkg.sv ***
/*
  types shared by the pwm channel.
  assumes the defines header is compiled alongside.
*/
package pwm_chan_pkg;
  typedef struct packed {
    logic [31:0] on_width;
    logic [31:0] cycle;
  } pwm_setting_t;
  typedef struct packed {
    logic loc_bad;
    logic mode_bad;
    logic range_bad;
  } pwm_check_t;
endpackage

// *** pwm_load_model.sv ***
/*
  load on the first coincidence output: measures the last high time and period.
  assumes a synchronous view of the output on the system clock.
*/
`timescale 1ns/1ps
module pwm_load_model (
  input  wire logic clk_in,
  input  wire logic pwm_in,
  output int        hi_len_out,
  output int        per_len_out
);
  logic prev = 1'b0;
  int   hi_cnt = 0;
  int   per_cnt = 0;
  // high time counted at each fall, period between rises; first period is junk
  always @(posedge clk_in) begin
    prev <= pwm_in;
    hi_cnt <= pwm_in ? hi_cnt + 1 : 0;
    per_cnt <= per_cnt + 1;
    if (prev && !pwm_in) hi_len_out <= hi_cnt;
    if (!prev && pwm_in) begin
      per_len_out <= per_cnt;
      per_cnt <= 1;
    end
  end
endmodule // pwm_load_model

// *** tb.sv ***
/*
  testbench of the pwm channel: register port tasks and one task per scenario.
  assumes the design runs with TICK_DIV of 2 so each 0.1 us unit is 2 clocks.
*/
`timescale 1ns/1ps
`include "pwm_chan_defines.svh"
module tb;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic        wr_en_in = 1'b0;
  logic        rd_en_in = 1'b0;
  logic [31:0] rd_data_out;
  logic        pwm_out;
  logic        irq_out;
  int          hi_len;
  int          per_len;
  int          bad_count = 0;
  int          num_checks = 0;
  counter_channel_pwm_output #(.TICK_DIV(2)) dut (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .pwm_out(pwm_out), .irq_out(irq_out));
  pwm_load_model load (.clk_in(clk_sys_in), .pwm_in(pwm_out), .hi_len_out(hi_len),
    .per_len_out(per_len));
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (exp !== got) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_sys_in);
    wr_en_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input string what, input logic [31:0] exp);
    @(posedge clk_sys_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_en_in <= 1'b0;
    #1 chk(what, exp, rd_data_out);
  endtask
  // clear flag and code, then read the code that comes back
  task automatic code_is(input logic [31:0] exp);
    wr(`ADDR_STATUS, 32'h1);
    rd(`ADDR_ERR_CODE, "error code", exp);
  endtask
  task automatic s_disabled();
    rd(`ADDR_STATUS, "flag after reset", 32'h1);
    code_is({16'h0, `CODE_MODE});
    wr(`ADDR_CTRL, 32'h6);
    code_is({16'h0, `CODE_MODE});
    wr(`ADDR_INT_MASK, 32'h1);
    repeat (3) @(posedge clk_sys_in);
    chk("irq unmasked", 32'h1, {31'h0, irq_out});
    wr(`ADDR_INT_MASK, 32'h0);
    repeat (3) @(posedge clk_sys_in);
    chk("irq masked", 32'h0, {31'h0, irq_out});
  endtask
  task automatic s_ranges();
    wr(`ADDR_ON_WIDTH, 32'h5);
    wr(`ADDR_CYCLE, 32'h32);
    wr(`ADDR_CTRL, 32'he);
    code_is({16'h0, `CODE_RANGE});
    wr(`ADDR_ON_WIDTH, 32'h33);
    code_is({16'h0, `CODE_RANGE});
    wr(`ADDR_ON_WIDTH, 32'ha);
    wr(`ADDR_CYCLE, 32'h0098_9681);
    code_is({16'h0, `CODE_RANGE});
    wr(`ADDR_CYCLE, 32'h32);
    wr(`ADDR_CTRL, 32'h2e);
    code_is({16'h0, `CODE_LOC});
    wr(`ADDR_CTRL, 32'he);
    code_is(32'h0);
    rd(`ADDR_STATUS, "flag cleared", 32'h0);
    wr(`ADDR_INT_STAT, 32'h7);
  endtask
  task automatic s_run();
    repeat (200) @(posedge clk_sys_in);
    chk("idle while request low", 32'h0, {31'h0, pwm_out});
    wr(`ADDR_CTRL, 32'hf);
    repeat (400) @(posedge clk_sys_in);
    chk("high length", 32'd20, hi_len);
    chk("period length", 32'd100, per_len);
    rd(`ADDR_INT_STAT, "start and wrap events", 32'h6);
    wr(`ADDR_CTRL, 32'he);
    repeat (4) @(posedge clk_sys_in);
    chk("stopped", 32'h0, {31'h0, pwm_out});
    wr(`ADDR_ON_WIDTH, 32'h0);
    wr(`ADDR_CTRL, 32'hf);
    repeat (300) @(posedge clk_sys_in);
    chk("zero high time", 32'h0, {31'h0, pwm_out});
    rd(`ADDR_STATUS, "running", 32'h2);
    wr(`ADDR_CYCLE, 32'h0);
    wr(`ADDR_CYCLE, 32'h32);
    rd(`ADDR_ERR_CODE, "mid-run fault code", {16'h0, `CODE_RANGE});
    rd(`ADDR_STATUS, "no restart while held", 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    s_disabled();
    s_ranges();
    s_run();
    tally_and_finish();
  end
  // watchdog well beyond the roughly 1000 cycles the scenarios need
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule // tb
